// File: sim/fsi_host_model.sv
// Host model: register port master for the fault supervisor.
// Assumes the bench calls its tasks; read data stand one cycle after the strobe.
`timescale 1ns/1ps
module fsi_host_model
  import fsi_pkg::*;
(
  // Clock and read data
  input  wire logic              i_clk,
  input  wire logic [DATA_W-1:0] i_rdata,
  // Register port
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata,
  output logic                   o_wr,
  output logic                   o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'h0;
    o_rd = 1'h0;
  end

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_wr <= 1'h1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'h0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_rd <= 1'h1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'h0;
    #1;
    d = i_rdata;
  endtask
endmodule

// File: sim/fsi_supervisor_test.sv
// Self-checking bench for the fault supervisor.
// Assumes the host model masters the register port; one 200 MHz clock.
`timescale 1ns/1ps
module fsi_supervisor_test;
  import fsi_pkg::*;
  // Enabled, transmit low, no fault
  localparam fsi_chan_in_t CH_IDLE = 6'h02;
  logic              i_clk, i_rstn, i_mode_serial, i_wakeup_pulse;
  logic [1:0]        i_regulator_select_strap, reg_sel;
  fsi_chan_in_t      i_chan1, i_chan2;
  fsi_supply_in_t    i_supply;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              wr, rd, f1, f1oe, f2, f2oe, c1out, c1oe, c2out, c2oe;
  logic              reg_en, rst_n, irq_n;
  int                fail_count, checks;

  fsi_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  fsi_supervisor dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_mode_serial(i_mode_serial),
    .i_regulator_select_strap(i_regulator_select_strap), .i_chan1(i_chan1),
    .i_chan2(i_chan2), .i_supply(i_supply), .i_wakeup_pulse(i_wakeup_pulse),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_chan1_fault_n(f1), .o_chan1_fault_n_oe(f1oe), .o_chan2_fault_n(f2),
    .o_chan2_fault_n_oe(f2oe), .o_chan1_out(c1out), .o_chan1_oe(c1oe),
    .o_chan2_out(c2out), .o_chan2_oe(c2oe), .o_regulator_enable(reg_en),
    .o_regulator_sel(reg_sel), .o_reset_n(rst_n), .o_irq_n(irq_n));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge i_clk) i_rstn <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'h1;
  endtask
  // One event of interrupt source i, then back to idle
  task automatic fire(input int i);
    @(posedge i_clk);
    case (i)
      0: i_chan2 <= 6'h12;
      1: i_wakeup_pulse <= 1'h1;
      2: i_chan2 <= 6'h06;
      3: i_chan1 <= 6'h06;
      4: i_supply.main_warn <= 1'h1;
      5: i_supply.aux_uv <= 1'h1;
      default: i_chan1 <= 6'h22;
    endcase
    @(posedge i_clk);
    i_chan1 <= CH_IDLE;
    i_chan2 <= (i == 0) ? 6'h0a : CH_IDLE;
    i_wakeup_pulse <= 1'h0;
    i_supply.main_warn <= 1'h0;
    i_supply.aux_uv <= 1'h0;
    @(posedge i_clk);
    i_chan2 <= CH_IDLE;
  endtask

  task automatic t_flags();
    @(posedge i_clk) i_chan1 <= 6'h22;
    i_chan2 <= 6'h22;
    cyc(3);
    chk("fault1_oe", 1, f1oe);
    chk("fault1_n", 0, f1);
    chk("fault2_oe", 1, f2oe);
    chk("fault2_n", 0, f2);
    @(posedge i_clk) i_chan1 <= 6'h06;
    i_chan2 <= CH_IDLE;
    cyc(3);
    chk("fault1_oe oc", 1, f1oe);
    chk("fault2_oe", 0, f2oe);
    @(posedge i_clk) i_mode_serial <= 1'h1;
    cyc(3);
    chk("fault1_oe serial", 0, f1oe);
    @(posedge i_clk) i_chan1 <= CH_IDLE;
    i_mode_serial <= 1'h0;
    cyc(3);
    chk("fault1_oe", 0, f1oe);
  endtask

  task automatic t_thermal();
    @(posedge i_clk) i_chan1 <= 6'h13;
    cyc(4);
    chk("chan1_oe sd", 0, c1oe);
    chk("chan2_oe", 1, c2oe);
    chk("reg_en", 1, reg_en);
    @(posedge i_clk) i_chan1 <= 6'h03;
    cyc(4);
    chk("chan1_oe wait", 0, c1oe);
    @(posedge i_clk) i_chan1 <= 6'h0b;
    cyc(4);
    chk("chan1_oe back", 1, c1oe);
    chk("chan1_out", 0, c1out);
    @(posedge i_clk) i_chan1 <= 6'h00;
    i_chan2 <= 6'h12;
    cyc(4);
    chk("chan1_oe off", 0, c1oe);
    chk("chan2_oe sd", 0, c2oe);
    @(posedge i_clk) i_chan1 <= CH_IDLE;
    i_chan2 <= 6'h0a;
    cyc(4);
    chk("chan1_oe", 1, c1oe);
    chk("chan2_oe back", 1, c2oe);
    chk("chan2_out", 1, c2out);
    @(posedge i_clk) i_chan2 <= CH_IDLE;
  endtask

  task automatic t_undervoltage_lockout();
    @(posedge i_clk) i_supply.main_uv <= 1'h1;
    cyc(3);
    chk("reset_n main", 0, rst_n);
    chk("chan1_oe", 0, c1oe);
    chk("chan2_oe", 0, c2oe);
    @(posedge i_clk) i_supply.main_uv <= 1'h0;
    i_supply.reg_uv <= 1'h1;
    cyc(3);
    chk("reset_n reg", 0, rst_n);
    @(posedge i_clk) i_supply.reg_uv <= 1'h0;
    cyc(3);
    chk("reset_n up", 1, rst_n);
    cyc(UNDERVOLTAGE_LOCKOUT_CYCLES - 10);
    chk("chan1_oe early", 0, c1oe);
    cyc(20);
    chk("chan1_oe late", 1, c1oe);
  endtask

  task automatic t_regsd();
    @(posedge i_clk) i_supply.reg_shutdown <= 1'h1;
    i_supply.reg_uv <= 1'h1;
    cyc(4);
    chk("reg_en sd", 0, reg_en);
    chk("reset_n sd", 0, rst_n);
    chk("chan2_oe sd", 0, c2oe);
    @(posedge i_clk) i_supply.reg_shutdown <= 1'h0;
    i_supply.reg_recovered <= 1'h1;
    cyc(6);
    chk("reg_en back", 1, reg_en);
    chk("reset_n wait", 0, rst_n);
    @(posedge i_clk) i_supply.reg_uv <= 1'h0;
    i_supply.reg_recovered <= 1'h0;
    cyc(6);
    chk("reset_n back", 1, rst_n);
    cyc(UNDERVOLTAGE_LOCKOUT_CYCLES + 20);
  endtask

  task automatic t_irq();
    logic [31:0] d;
    @(posedge i_clk) i_mode_serial <= 1'h1;
    host.reg_read(ADDR_IRQ_STATUS, d);
    host.reg_write(ADDR_IRQ_MASK, 32'h7f);
    host.reg_read(ADDR_IRQ_MASK, d);
    chk("mask", 32'h7f, d);
    for (int i = 0; i < IRQ_N; i++) begin
      fire(i);
      cyc(3);
      chk("irq_n masked", 1, irq_n);
      host.reg_read(ADDR_IRQ_STATUS, d);
      chk("status", 32'h1 << i, d);
    end
    host.reg_write(ADDR_IRQ_MASK, 32'h0);
    fire(IRQ_CHAN1_OC);
    cyc(3);
    chk("irq_n event", 0, irq_n);
    cyc(20);
    chk("irq_n held", 0, irq_n);
    host.reg_read(ADDR_IRQ_STATUS, d);
    chk("status oc1", 32'h8, d);
    cyc(2);
    chk("irq_n clear", 1, irq_n);
    @(posedge i_clk) i_supply.main_warn <= 1'h1;
    cyc(3);
    host.reg_read(ADDR_IRQ_STATUS, d);
    host.reg_read(ADDR_IRQ_STATUS, d);
    chk("status live", 32'h10, d);
    chk("irq_n live", 0, irq_n);
    @(posedge i_clk) i_supply.main_warn <= 1'h0;
    cyc(2);
    host.reg_read(ADDR_IRQ_STATUS, d);
    host.reg_read(ADDR_IRQ_STATUS, d);
    chk("status gone", 32'h0, d);
    host.reg_write(ADDR_IRQ_MASK, 32'h7f);
    fire(IRQ_WAKEUP);
    cyc(3);
    chk("irq_n masked", 1, irq_n);
    host.reg_write(ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq_n unmask", 0, irq_n);
    host.reg_read(8'h40, d);
    chk("unmapped", 32'h0, d);
    @(posedge i_clk) i_mode_serial <= 1'h0;
    host.reg_read(ADDR_IRQ_STATUS, d);
    fire(IRQ_WAKEUP);
    cyc(3);
    chk("irq_n pin mode", 1, irq_n);
  endtask

  task automatic t_strap();
    logic [31:0] d;
    @(posedge i_clk) i_regulator_select_strap <= STRAP_5V;
    cyc(3);
    chk("reg_sel kept", STRAP_MAIN_3V3, reg_sel);
    @(posedge i_clk) i_regulator_select_strap <= STRAP_AUX_3V3;
    do_reset();
    cyc(4);
    chk("reg_sel aux", STRAP_AUX_3V3, reg_sel);
    // Latched strap visible, still waiting out the delay
    host.reg_read(ADDR_SUP_STATUS, d);
    chk("sup_status", (32'(STRAP_AUX_3V3) << SUP_SEL_LSB) | (32'h1 << SUP_STRAP_TAKEN), d);
    @(posedge i_clk) i_supply.aux_uv <= 1'h1;
    cyc(4);
    chk("reg_en aux", 0, reg_en);
    chk("reset_n aux", 0, rst_n);
    @(posedge i_clk) i_supply.aux_uv <= 1'h0;
    cyc(4);
    chk("reg_en aux ok", 1, reg_en);
  endtask

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    i_rstn = 1'h0;
    i_mode_serial = 1'h0;
    i_wakeup_pulse = 1'h0;
    i_regulator_select_strap = STRAP_MAIN_3V3;
    i_chan1 = CH_IDLE;
    i_chan2 = CH_IDLE;
    i_supply = 6'h00;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'h1;
    cyc(UNDERVOLTAGE_LOCKOUT_CYCLES + 20);
    chk("reg_sel main", STRAP_MAIN_3V3, reg_sel);
    chk("chan1_oe run", 1, c1oe);
    t_flags();
    t_thermal();
    t_undervoltage_lockout();
    t_regsd();
    t_irq();
    t_strap();
    print_verdict();
  end
endmodule

// File: src/fsi_pkg.sv
// Constants, carriers and state codes for the fault supervisor.
// Assumes a single 200 MHz clock and a plain register port.
package fsi_pkg;

  // Clock and recovery timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int T_UNDERVOLTAGE_LOCKOUT_US      = 20;
  localparam int UNDERVOLTAGE_LOCKOUT_CYCLES    = (T_UNDERVOLTAGE_LOCKOUT_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int UNDERVOLTAGE_LOCKOUT_CNT_W     = 12;

  // Register port
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h04;
  localparam logic [7:0] ADDR_SUP_STATUS = 8'h08;

  // Interrupt bit positions
  localparam int IRQ_N          = 7;
  localparam int IRQ_TSD        = 0;
  localparam int IRQ_WAKEUP     = 1;
  localparam int IRQ_CHAN2_OC   = 2;
  localparam int IRQ_CHAN1_OC   = 3;
  localparam int IRQ_MAIN_WARN  = 4;
  localparam int IRQ_AUX_UV     = 5;
  localparam int IRQ_TEMP_WARN  = 6;
  localparam logic [6:0] IRQ_MASK_RESET = 7'h00;
  localparam logic [6:0] IRQ_STATUS_RESET = 7'h00;

  // Supervisor status fields
  localparam int SUP_CHAN_SD_LSB = 0;
  localparam int SUP_REG_SD      = 2;
  localparam int SUP_LOCKOUT     = 3;
  localparam int SUP_READY       = 4;
  localparam int SUP_SERIAL      = 5;
  localparam int SUP_SEL_LSB     = 6;
  localparam int SUP_STRAP_TAKEN = 8;

  // Regulator select strap codes
  localparam logic [1:0] STRAP_MAIN_3V3 = 2'h0;
  localparam logic [1:0] STRAP_AUX_3V3  = 2'h1;
  localparam logic [1:0] STRAP_5V       = 2'h2;

  typedef struct packed {
    logic warn;
    logic shutdown;
    logic recovered;
    logic overcurrent;
    logic drive_enable;
    logic transmit_in;
  } fsi_chan_in_t;

  typedef struct packed {
    logic main_uv;
    logic main_warn;
    logic aux_uv;
    logic reg_uv;
    logic reg_shutdown;
    logic reg_recovered;
  } fsi_supply_in_t;

  typedef enum logic [2:0] {
    SUP_LOCK = 3'b001,
    SUP_WAIT = 3'b010,
    SUP_RUN  = 3'b100
  } fsi_sup_state_t;

endpackage

// File: src/fsi_supervisor.sv
// Fault supervisor: thermal and supply protection, reset and sticky interrupts.
// Assumes all sensor inputs are already synchronous, one clock, plain register port.
//
// Operation
// - Chan1 warning drives its fault flag low
// - Chan1 shutdown disables only chan1 driver
// - Chan1 re-enabled after hysteresis recovery
// - Chan2 warning drives its fault flag low
// - Chan2 shutdown disables only chan2 driver
// - Chan2 re-enabled after hysteresis recovery
// - Regulator shutdown: regulator, drivers off, reset
// - Regulator recovery, reset waits for output
// - Strap sampled once at power-up, held
// - Aux selected but low: regulator off, reset
// - Supply undervoltage: reset low, drivers off
// - Supplies good: reset high, delayed driver enable
// - Serial mode: push-pull interrupt low on event
// - One interrupt bit per event source; IRQ_TSD is shared by all three shutdowns, IRQ_TEMP_WARN by both warnings
// - Masked sources set bits, never pull low
// - Interrupt bits sticky until host clears
// - Read clears bits, output returns high; a bit whose source is still active in the read cycle stays set
// - All masked holds interrupt output high
// - Unmasking pending bits pulls output low
// - Mode input low pin, high serial
// - Pin mode: overcurrent also lowers fault flag
// - Fault flag released when causes clear
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module fsi_supervisor
  import fsi_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // Mode and strap
  input  wire logic                 i_mode_serial,
  input  wire logic [1:0]           i_regulator_select_strap,
  // Sensors and driver controls
  input  wire fsi_chan_in_t         i_chan1,
  input  wire fsi_chan_in_t         i_chan2,
  input  wire fsi_supply_in_t       i_supply,
  input  wire logic                 i_wakeup_pulse,
  // Register port
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [DATA_W-1:0]    o_rdata,
  // Fault flags, open drain
  output logic                      o_chan1_fault_n,
  output logic                      o_chan1_fault_n_oe,
  output logic                      o_chan2_fault_n,
  output logic                      o_chan2_fault_n_oe,
  // Drivers
  output logic                      o_chan1_out,
  output logic                      o_chan1_oe,
  output logic                      o_chan2_out,
  output logic                      o_chan2_oe,
  // Regulator, reset and interrupt
  output logic                      o_regulator_enable,
  output logic      [1:0]           o_regulator_sel,
  output logic                      o_reset_n,
  output logic                      o_irq_n
);

  fsi_chan_in_t      chan_in [2];
  logic [1:0]        chan_sd;
  logic [1:0]        fault_oe;
  logic [1:0]        drv_out;
  logic [1:0]        drv_oe;
  logic              reg_sd;
  logic [1:0]        strap_sel;
  logic              strap_taken;
  logic              aux_missing;
  logic              lockout;
  logic              drivers_ready;
  fsi_sup_state_t    state;
  fsi_sup_state_t    next_state;
  logic [UNDERVOLTAGE_LOCKOUT_CNT_W-1:0] undervoltage_lockout_cnt;
  logic [IRQ_N-1:0]  irq_status;
  logic [IRQ_N-1:0]  irq_mask;
  logic [IRQ_N-1:0]  irq_event;
  logic [IRQ_N-1:0]  next_irq_status;
  logic              rd_status;
  logic              irq_pending;

  assign chan_in[0] = i_chan1;
  assign chan_in[1] = i_chan2;

  // Per-channel thermal latch, fault flag and driver gating
  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        chan_sd[c] <= 1'b0;
      end else if (chan_in[c].shutdown) begin
        chan_sd[c] <= 1'b1;
      end else if (chan_in[c].recovered) begin
        chan_sd[c] <= 1'b0;
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        fault_oe[c] <= 1'b0;
      end else begin
        fault_oe[c] <= chan_in[c].warn | (!i_mode_serial & chan_in[c].overcurrent);
      end
    end

    // drivers off until recovery delay ends
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        drv_oe[c]  <= 1'b0;
        drv_out[c] <= 1'b0;
      end else begin
        drv_oe[c]  <= drivers_ready & !chan_sd[c] & !reg_sd & chan_in[c].drive_enable;
        drv_out[c] <= !chan_in[c].transmit_in;
      end
    end

    ch_warn_flag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      chan_in[c].warn |=> fault_oe[c])
      else $error("fault flag not driven on thermal warning");

    ch_sd_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      chan_in[c].shutdown |=> ##1 !drv_oe[c])
      else $error("driver still on after its shutdown");

    ch_release_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !chan_in[c].warn && !chan_in[c].overcurrent |=> !fault_oe[c])
      else $error("fault flag held after causes cleared");
  end

  // Fault data tied low; flops feed the fault enables and driver ports directly
  assign o_chan1_fault_n    = 1'b0;
  assign o_chan2_fault_n    = 1'b0;
  assign o_chan1_fault_n_oe = fault_oe[0];
  assign o_chan2_fault_n_oe = fault_oe[1];
  assign o_chan1_oe         = drv_oe[0];
  assign o_chan2_oe         = drv_oe[1];
  assign o_chan1_out        = drv_out[0];
  assign o_chan2_out        = drv_out[1];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_sd <= 1'b0;
    end else if (i_supply.reg_shutdown) begin
      reg_sd <= 1'b1;
    end else if (i_supply.reg_recovered) begin
      reg_sd <= 1'b0;
    end
  end

  // strap caught once after power-up release
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_taken <= 1'b0;
      strap_sel   <= STRAP_MAIN_3V3;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_sel   <= i_regulator_select_strap;
    end
  end

  assign aux_missing = strap_taken & (strap_sel == STRAP_AUX_3V3) & i_supply.aux_uv;
  // any cause holds the device in lockout
  assign lockout = !strap_taken | i_supply.main_uv | i_supply.reg_uv | reg_sd | aux_missing;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_regulator_enable <= 1'b0;
      o_regulator_sel    <= STRAP_MAIN_3V3;
      o_reset_n          <= 1'b0;
    end else begin
      o_regulator_enable <= strap_taken & !reg_sd & !aux_missing;
      o_regulator_sel    <= strap_sel;
      o_reset_n          <= !lockout;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SUP_LOCK: begin
        if (!lockout) begin
          next_state = SUP_WAIT;
        end
      end
      SUP_WAIT: begin
        if (lockout) begin
          next_state = SUP_LOCK;
        end else if (undervoltage_lockout_cnt == UNDERVOLTAGE_LOCKOUT_CNT_W'(UNDERVOLTAGE_LOCKOUT_CYCLES - 1)) begin
          next_state = SUP_RUN;
        end
      end
      SUP_RUN: begin
        if (lockout) begin
          next_state = SUP_LOCK;
        end
      end
      default: next_state = SUP_LOCK;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SUP_LOCK;
    end else begin
      state <= next_state;
    end
  end

  // delay counter runs only while waiting
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      undervoltage_lockout_cnt <= '0;
    end else if (state == SUP_WAIT && !lockout) begin
      undervoltage_lockout_cnt <= undervoltage_lockout_cnt + UNDERVOLTAGE_LOCKOUT_CNT_W'(1);
    end else begin
      undervoltage_lockout_cnt <= '0;
    end
  end

  assign drivers_ready = (state == SUP_RUN) & !lockout;

  // one event line per interrupt source
  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_TSD]       = chan_in[0].shutdown | chan_in[1].shutdown | i_supply.reg_shutdown;
    irq_event[IRQ_WAKEUP]    = i_wakeup_pulse;
    irq_event[IRQ_CHAN2_OC]  = chan_in[1].overcurrent;
    irq_event[IRQ_CHAN1_OC]  = chan_in[0].overcurrent;
    irq_event[IRQ_MAIN_WARN] = i_supply.main_warn;
    irq_event[IRQ_AUX_UV]    = i_supply.aux_uv;
    irq_event[IRQ_TEMP_WARN] = chan_in[0].warn | chan_in[1].warn;
  end

  assign rd_status = i_rd & (i_addr == ADDR_IRQ_STATUS);

  // sticky, read-clear, set wins over clear
  assign next_irq_status = (rd_status ? '0 : irq_status) | irq_event;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_status <= IRQ_STATUS_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Mask bit high blocks the source from the output only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
      irq_mask <= i_wdata[IRQ_N-1:0];
    end
  end

  assign irq_pending = |(irq_status & ~irq_mask);

  // push-pull low only in serial mode
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= !(i_mode_serial & irq_pending);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= '0;
      case (i_addr)
        ADDR_IRQ_STATUS: o_rdata[IRQ_N-1:0] <= irq_status;
        ADDR_IRQ_MASK:   o_rdata[IRQ_N-1:0] <= irq_mask;
        ADDR_SUP_STATUS: begin
          o_rdata[SUP_CHAN_SD_LSB +: 2] <= chan_sd;
          o_rdata[SUP_REG_SD]           <= reg_sd;
          o_rdata[SUP_LOCKOUT]          <= lockout;
          o_rdata[SUP_READY]            <= drivers_ready;
          o_rdata[SUP_SERIAL]           <= i_mode_serial;
          o_rdata[SUP_SEL_LSB +: 2]     <= strap_sel;
          o_rdata[SUP_STRAP_TAKEN]      <= strap_taken;
        end
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_wait_done;
    state == SUP_WAIT ##1 state == SUP_RUN;
  endsequence

  sequence s_status_read;
    rd_status ##1 1'b1;
  endsequence

  reg_sd_off_a: assert property (
    reg_sd |=> !o_regulator_enable && !o_reset_n && !drv_oe[0] && !drv_oe[1])
    else $error("regulator shutdown did not stop regulator and drivers");

  uv_reset_a: assert property (
    i_supply.main_uv || i_supply.reg_uv |=> !o_reset_n ##0 (state == SUP_LOCK))
    else $error("undervoltage did not assert reset");

  aux_missing_a: assert property (
    aux_missing |=> !o_regulator_enable && !o_reset_n)
    else $error("missing aux supply left regulator on");

  undervoltage_lockout_delay_a: assert property (
    s_wait_done |-> $past(undervoltage_lockout_cnt) == UNDERVOLTAGE_LOCKOUT_CNT_W'(UNDERVOLTAGE_LOCKOUT_CYCLES - 1))
    else $error("drivers enabled before recovery delay");

  strap_hold_a: assert property (
    strap_taken |=> $stable(strap_sel))
    else $error("strap choice changed after power-up");

  sticky_set_a: assert property (
    irq_status != '0 && !rd_status |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("interrupt bit dropped without a read");

  read_clear_a: assert property (
    s_status_read |-> irq_status == $past(irq_event))
    else $error("read did not clear bits down to live events");

  masked_high_a: assert property (
    (&irq_mask) |=> o_irq_n)
    else $error("interrupt low while all sources masked");

  irq_low_a: assert property (
    i_mode_serial && irq_pending |=> !o_irq_n)
    else $error("pending unmasked bit did not pull interrupt low");

  pin_mode_irq_a: assert property (
    !i_mode_serial |=> o_irq_n)
    else $error("interrupt driven low in pin mode");

endmodule
